// ### src/bpt_pkg.sv
package bpt_pkg;
	// Register indices: byte address is four times the index
	localparam int I_RECOV_TIME = 0;
	localparam int I_HWD_TMO = 1;
	localparam int I_LD_ACT = 2;
	localparam int I_LD_RETRY = 3;
	localparam int I_LD_TMO_HRS = 4;
	localparam int I_PTO_THR = 5;
	localparam int I_PRECHARGE_LIMIT_DELAY = 6;
	localparam int I_PTO_RSTQ = 7;
	localparam int I_CU_THR = 8;
	localparam int I_CU_DELAY = 9;
	localparam int I_SUV_THR = 10;
	localparam int I_SAFETY_LOW_CELL_DELAY = 11;
	localparam int I_SOV_THR = 12;
	localparam int I_SOV_DELAY = 13;
	localparam int I_DSG_THR = 14;
	localparam int NCFG = 15;
	localparam int I_CTRL = 15;
	localparam int I_STATUS = 16;
	localparam int I_MASK = 17;
	localparam int I_STATE = 18;

	localparam logic [15:0] RST_RECOV_TIME = 16'h0003;
	localparam logic [15:0] RST_HWD_TMO = 16'h003c;
	localparam logic [15:0] RST_LD_ACT = 16'h0000;
	localparam logic [15:0] RST_LD_RETRY = 16'h0032;
	localparam logic [15:0] RST_LD_TMO_HRS = 16'h0001;
	localparam logic [15:0] RST_PTO_THR = 16'h00fa;
	localparam logic [15:0] RST_PRECHARGE_LIMIT_DELAY = 16'h0708;
	localparam logic [15:0] RST_PTO_RSTQ = 16'h0002;
	localparam logic [15:0] RST_CU_THR = 16'h05dc;
	localparam logic [15:0] RST_CU_DELAY = 16'h0002;
	localparam logic [15:0] RST_SUV_THR = 16'h0898;
	localparam logic [15:0] RST_SAFETY_LOW_CELL_DELAY = 16'h0005;
	localparam logic [15:0] RST_SOV_THR = 16'h1194;
	localparam logic [15:0] RST_SOV_DELAY = 16'h0005;
	localparam logic [15:0] RST_DSG_THR = 16'h0064;
	localparam logic [15:0] RST_CTRL = 16'h0001;
	localparam logic [15:0] RST_MASK = 16'h0000;

	localparam logic [15:0] CFG_RST [NCFG] = '{RST_RECOV_TIME, RST_HWD_TMO, RST_LD_ACT,
		RST_LD_RETRY, RST_LD_TMO_HRS, RST_PTO_THR, RST_PRECHARGE_LIMIT_DELAY, RST_PTO_RSTQ, RST_CU_THR,
		RST_CU_DELAY, RST_SUV_THR, RST_SAFETY_LOW_CELL_DELAY, RST_SOV_THR, RST_SOV_DELAY, RST_DSG_THR};
	localparam logic [15:0] CFG_MASK [NCFG] = '{16'h00ff, 16'hffff, 16'h00ff, 16'h00ff,
		16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h00ff, 16'hffff, 16'h00ff,
		16'hffff, 16'h00ff, 16'hffff};

	localparam int CTRL_CU_EN = 0;
	localparam int CTRL_LD_RETRY = 1;

	localparam int ST_HWD = 0;
	localparam int ST_PTO = 1;
	localparam int ST_COPPER_DEPOSITION_CHECK = 2;
	localparam int ST_SUV = 3;
	localparam int ST_SOV = 4;
	localparam int ST_LD_RECOV = 5;
	localparam int ST_LD_TMO = 6;
	localparam int ST_RECOV = 7;
	localparam int NST = 8;

	localparam int CLK_PERIOD_NS = 20;
	localparam int SEC_NS = 1000000000;
	localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
	localparam int SEC_PER_HOUR = 3600;

	typedef enum logic [1:0] {LD_IDLE, LD_ON, LD_OFF, LD_EXPIRED} bpt_ld_t;
	typedef enum logic [1:0] {CU_CHECK, CU_PASS, CU_FAIL} bpt_cu_t;
endpackage : bpt_pkg

// ### src/bpt_top.sv
// How it works
// - recovery after condition holds configured seconds
// - watchdog fault after silent host period
// - zero active time disables load recovery
// - source on active time, then retry
// - pin above three volts means removal
// - zero retry keeps source on
// - nonzero retry holds source off
// - hour timeout stops load detection
// - low precharge current suspends timer
// - precharge timer counts, trips at delay
// - discharged charge resets precharge timer
// - copper check holds FETs until good
// - copper check fails on low cell
// - low cell voltage permanent fail
// - high cell voltage permanent fail
//
// Local design decisions: register access over APB and the register offsets.
module bpt_qual #(
	parameter int W = 8
) (
	input wire logic clk, // System clock
	input wire logic rst_n, // Synchronous reset
	input wire logic ce, // Clock enable
	input wire logic tick, // One-second tick
	input wire logic clr, // Restart count at once
	input wire logic cond, // Qualifying condition
	input wire logic [W-1:0] delay, // Seconds to qualify
	output logic met // Condition has held long enough
);
	logic [W-1:0] cnt_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= '0;
			met <= 1'b0;
		end else if (ce) begin
			if (clr || (tick && !cond)) begin
				cnt_q <= '0;
				met <= 1'b0;
			end else if (tick && !met) begin
				if (({1'b0, cnt_q} + (W+1)'(1)) >= {1'b0, delay})
					met <= 1'b1;
				cnt_q <= cnt_q + W'(1);
			end
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	qual_count_a: assert property (ce && tick && !clr && cond && !met
		&& ({1'b0, cnt_q} + (W+1)'(1)) >= {1'b0, delay} |=> met)
		else $error("qualifier missed its delay");
	qual_drop_a: assert property (ce && (clr || (tick && !cond)) |=> !met && cnt_q == '0)
		else $error("qualifier not restarted");
endmodule : bpt_qual

module bpt_top import bpt_pkg::*; #(
	parameter int unsigned SEC_CYCLES_P = SEC_CYCLES,
	parameter int NREC = 4
) (
	input wire logic clk, // 50 MHz clock
	input wire logic rst_n, // Synchronous reset
	input wire logic ce, // Clock enable, freezes all state
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic host_comm_evt, // Host transaction pulse
	input wire logic [15:0] min_cell_mv, // Minimum cell voltage
	input wire logic [15:0] max_cell_mv, // Maximum cell voltage
	input wire logic signed [15:0] current_user, // Signed current
	input wire logic precharge_mode, // Precharge mode active
	input wire logic dsg_latch_fault, // Latched discharge fault present
	input wire logic ld_pin_high, // Sense pin above three volts
	input wire logic [NREC-1:0] recov_cond, // Recovery conditions
	output logic [NREC-1:0] recov_done, // Recovery qualified
	output logic ld_source_en, // Load sense current source on
	output logic ld_recover, // Load removal pulse
	output logic fet_hold, // Keep FETs off
	output logic precharge_suspend_flag, // Precharge timer suspended
	output logic precharge_limit_protection, // Precharge timeout tripped
	output logic [2:0] perm_fail, // Copper, low cell, high cell
	output logic irq // Level interrupt
);
	logic [15:0] cfg_q [NCFG];
	logic [15:0] ctrl_q;
	logic [NST-1:0] status_q, mask_q, events;
	logic [31:0] prdata_q, rd_val, sec_cnt_q;
	logic pslverr_q, rd_err, tick, wr, acc;
	logic [5:0] idx;
	logic retry_cmd, cu_en;

	assign idx = paddr[7:2];
	assign pready = psel & penable & ce;
	assign wr = pready & pwrite;
	assign acc = ce & psel & ~penable;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign retry_cmd = wr && idx == 6'(I_CTRL) && pwdata[CTRL_LD_RETRY];
	assign cu_en = ctrl_q[CTRL_CU_EN];

	assign tick = sec_cnt_q == 32'(SEC_CYCLES_P - 1);
	always_ff @(posedge clk) begin
		if (!rst_n)
			sec_cnt_q <= '0;
		else if (ce)
			sec_cnt_q <= tick ? '0 : sec_cnt_q + 32'h1;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_q <= CFG_RST;
			ctrl_q <= RST_CTRL;
			mask_q <= NST'(RST_MASK);
		end else if (wr) begin
			for (int i = 0; i < NCFG; i++)
				if (idx == 6'(i))
					cfg_q[i] <= pwdata[15:0] & CFG_MASK[i];
			if (idx == 6'(I_CTRL))
				ctrl_q[CTRL_CU_EN] <= pwdata[CTRL_CU_EN];
			if (idx == 6'(I_MASK))
				mask_q <= pwdata[NST-1:0];
		end
	end

	// Hardware set wins over a same-cycle write-one clear
	always_ff @(posedge clk) begin
		if (!rst_n)
			status_q <= '0;
		else if (ce)
			status_q <= (status_q & ~((wr && idx == 6'(I_STATUS)) ? pwdata[NST-1:0] : '0))
				| events;
	end
	assign irq = |(status_q & mask_q);

	generate
		for (genvar g = 0; g < NREC; g++) begin : g_rec
			bpt_qual #(.W(8)) u_rec (
				.clk(clk), .rst_n(rst_n), .ce(ce), .tick(tick), .clr(1'b0),
				.cond(recov_cond[g]), .delay(cfg_q[I_RECOV_TIME][7:0]), .met(recov_done[g])
			);
		end
	endgenerate

	logic hwd_met, suv_met, sov_met, cu_ok, cu_bad;
	logic [4:0] met_q;
	bpt_cu_t cu_q;

	bpt_qual #(.W(16)) u_hwd (
		.clk(clk), .rst_n(rst_n), .ce(ce), .tick(tick), .clr(host_comm_evt),
		.cond(1'b1), .delay(cfg_q[I_HWD_TMO]), .met(hwd_met)
	);
	bpt_qual #(.W(8)) u_suv (
		.clk(clk), .rst_n(rst_n), .ce(ce), .tick(tick), .clr(1'b0),
		.cond(min_cell_mv <= cfg_q[I_SUV_THR]), .delay(cfg_q[I_SAFETY_LOW_CELL_DELAY][7:0]), .met(suv_met)
	);
	bpt_qual #(.W(8)) u_sov (
		.clk(clk), .rst_n(rst_n), .ce(ce), .tick(tick), .clr(1'b0),
		.cond(max_cell_mv >= cfg_q[I_SOV_THR]), .delay(cfg_q[I_SOV_DELAY][7:0]), .met(sov_met)
	);
	bpt_qual #(.W(8)) u_cuok (
		.clk(clk), .rst_n(rst_n), .ce(ce), .tick(tick), .clr(cu_q != CU_CHECK || !cu_en),
		.cond(min_cell_mv >= cfg_q[I_CU_THR]), .delay(cfg_q[I_CU_DELAY][7:0]), .met(cu_ok)
	);
	bpt_qual #(.W(8)) u_cubad (
		.clk(clk), .rst_n(rst_n), .ce(ce), .tick(tick), .clr(cu_q != CU_CHECK || !cu_en),
		.cond(min_cell_mv < cfg_q[I_CU_THR]), .delay(cfg_q[I_CU_DELAY][7:0]), .met(cu_bad)
	);

	always_ff @(posedge clk) begin
		if (!rst_n)
			cu_q <= CU_CHECK;
		else if (ce && cu_en && cu_q == CU_CHECK) begin
			if (cu_ok)
				cu_q <= CU_PASS;
			else if (cu_bad)
				cu_q <= CU_FAIL;
		end
	end
	assign fet_hold = cu_en && cu_q != CU_PASS;

	// Permanent fails stay latched until reset, whatever software clears in status
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			perm_fail <= '0;
			met_q <= '0;
		end else if (ce) begin
			met_q <= {hwd_met, suv_met, sov_met, cu_q == CU_FAIL, |recov_done};
			if (cu_q == CU_FAIL)
				perm_fail[0] <= 1'b1;
			if (suv_met)
				perm_fail[1] <= 1'b1;
			if (sov_met)
				perm_fail[2] <= 1'b1;
		end
	end

	// Precharge timer
	logic [15:0] pto_cnt_q;
	logic [31:0] dsg_acc_q, dsg_goal;
	logic [16:0] dsg_mag;
	logic pto_above, pto_run, dsg_active, precharge_limit_reset_charge, pto_hit;

	assign pto_above = $signed(current_user) > $signed(cfg_q[I_PTO_THR]);
	assign pto_run = precharge_mode && pto_above;
	assign dsg_mag = 17'h0 - {current_user[15], current_user};
	assign dsg_active = !current_user[15] ? 1'b0 : dsg_mag > {1'b0, cfg_q[I_DSG_THR]};
	assign dsg_goal = 32'(cfg_q[I_PTO_RSTQ]) * 32'(SEC_PER_HOUR);
	assign precharge_limit_reset_charge = dsg_acc_q >= dsg_goal && dsg_active;
	assign pto_hit = ({1'b0, pto_cnt_q} + 17'h1) >= {1'b0, cfg_q[I_PRECHARGE_LIMIT_DELAY]};
	assign precharge_suspend_flag = precharge_mode && !pto_above;

	// continuous discharge charge in user-amp seconds
	always_ff @(posedge clk) begin
		if (!rst_n)
			dsg_acc_q <= '0;
		else if (ce) begin
			if (!dsg_active || precharge_limit_reset_charge)
				dsg_acc_q <= '0;
			else if (tick)
				dsg_acc_q <= dsg_acc_q + 32'(dsg_mag);
		end
	end

	// count and trip, hold when suspended
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pto_cnt_q <= '0;
			precharge_limit_protection <= 1'b0;
		end else if (ce) begin
			if (precharge_limit_reset_charge) begin
				pto_cnt_q <= '0;
				precharge_limit_protection <= 1'b0;
			end else if (tick && pto_run && !precharge_limit_protection) begin
				pto_cnt_q <= pto_cnt_q + 16'h1;
				if (pto_hit)
					precharge_limit_protection <= 1'b1;
			end
		end
	end

	// Load removal detection
	bpt_ld_t ld_q;
	logic [7:0] ld_sec_q;
	logic [31:0] ld_run_q, ld_goal;
	logic ld_expire, ld_phase_end, ld_act_zero;

	assign ld_goal = 32'(cfg_q[I_LD_TMO_HRS]) * 32'(SEC_PER_HOUR);
	assign ld_expire = tick && (ld_run_q + 32'h1) >= ld_goal;
	assign ld_phase_end = ({1'b0, ld_sec_q} + 9'h1) >=
		{1'b0, (ld_q == LD_ON) ? cfg_q[I_LD_ACT][7:0] : cfg_q[I_LD_RETRY][7:0]};
	assign ld_act_zero = cfg_q[I_LD_ACT][7:0] == 8'h0;
	assign ld_source_en = ld_q == LD_ON;
	// removal only seen while source is on
	assign ld_recover = ce && ld_q == LD_ON && ld_pin_high && dsg_latch_fault;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ld_q <= LD_IDLE;
			ld_sec_q <= '0;
			ld_run_q <= '0;
		end else if (ce) begin
			if (tick)
				ld_sec_q <= ld_sec_q + 8'h1;
			if (tick)
				ld_run_q <= ld_run_q + 32'h1;
			unique case (ld_q)
				LD_IDLE: begin
					if (dsg_latch_fault && !ld_act_zero) begin
						ld_q <= LD_ON;
						ld_sec_q <= '0;
						ld_run_q <= '0;
					end
				end
				LD_ON, LD_OFF: begin
					if (!dsg_latch_fault || ld_act_zero || ld_recover)
						ld_q <= LD_IDLE;
					else if (ld_expire)
						ld_q <= LD_EXPIRED;
					// on period, zero retry stays on, off period
					else if (tick && ld_phase_end
						&& !(ld_q == LD_ON && cfg_q[I_LD_RETRY][7:0] == 8'h0)) begin
						ld_q <= (ld_q == LD_ON) ? LD_OFF : LD_ON;
						ld_sec_q <= '0;
					end
				end
				LD_EXPIRED: begin
					if (!dsg_latch_fault || retry_cmd)
						ld_q <= LD_IDLE;
				end
			endcase
		end
	end

	always_comb begin
		events = '0;
		events[ST_HWD] = hwd_met && !met_q[4];
		events[ST_SUV] = suv_met && !met_q[3];
		events[ST_SOV] = sov_met && !met_q[2];
		events[ST_COPPER_DEPOSITION_CHECK] = cu_q == CU_FAIL && !met_q[1];
		events[ST_RECOV] = |recov_done && !met_q[0];
		events[ST_PTO] = tick && pto_run && pto_hit && !precharge_limit_protection && !precharge_limit_reset_charge;
		events[ST_LD_RECOV] = ld_recover;
		events[ST_LD_TMO] = ce && (ld_q == LD_ON || ld_q == LD_OFF) && ld_expire
			&& dsg_latch_fault && !ld_act_zero && !ld_recover;
	end

	always_comb begin
		rd_val = '0;
		rd_err = 1'b0;
		if (idx < 6'(NCFG))
			rd_val = 32'(cfg_q[idx[3:0]]);
		else if (idx == 6'(I_CTRL))
			rd_val = 32'(ctrl_q);
		else if (idx == 6'(I_STATUS))
			rd_val = 32'(status_q);
		else if (idx == 6'(I_MASK))
			rd_val = 32'(mask_q);
		else if (idx == 6'(I_STATE))
			rd_val = {22'h0, ld_q, cu_q, precharge_limit_protection, precharge_suspend_flag,
				fet_hold, ld_source_en, 2'h0};
		else
			rd_err = 1'b1;
	end

	// Read data is sampled in the setup cycle so it comes from a flop
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end else if (acc) begin
			prdata_q <= pwrite ? '0 : rd_val;
			pslverr_q <= rd_err;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence ld_armed_s;
		ce && ld_q == LD_IDLE && dsg_latch_fault && !ld_act_zero;
	endsequence
	sequence ld_on_s;
		ld_q == LD_ON && ld_run_q == 32'h0;
	endsequence

	ld_arm_a: assert property (ld_armed_s |=> ld_on_s)
		else $error("load sense not armed with fresh timeout");
	ld_zero_a: assert property (ce && ld_act_zero |=> !ld_source_en)
		else $error("load sense on with zero active time");
	ld_recov_a: assert property (ld_recover |=> ld_q == LD_IDLE)
		else $error("load removal did not end sensing");
	ld_hold_a: assert property (ce && ld_q == LD_ON && tick && dsg_latch_fault && !ld_recover
		&& !ld_expire && !ld_act_zero && cfg_q[I_LD_RETRY][7:0] == 8'h0 |=> ld_q == LD_ON)
		else $error("source dropped with zero retry");
	ld_off_a: assert property (ce && ld_q == LD_OFF && tick && !ld_phase_end && dsg_latch_fault
		&& !ld_expire && !ld_act_zero |=> ld_q == LD_OFF)
		else $error("source back on early");
	ld_tmo_a: assert property (events[ST_LD_TMO] |=> ld_q == LD_EXPIRED ##1 status_q[ST_LD_TMO])
		else $error("load timeout not reported");
	pto_susp_a: assert property (ce && precharge_suspend_flag && !precharge_limit_reset_charge
		|=> pto_cnt_q == $past(pto_cnt_q))
		else $error("precharge timer moved while suspended");
	pto_trip_a: assert property (ce && tick && pto_run && pto_hit && !precharge_limit_reset_charge
		|=> precharge_limit_protection)
		else $error("precharge timeout missed");
	pto_rst_a: assert property (ce && precharge_limit_reset_charge |=> pto_cnt_q == 16'h0 && dsg_acc_q == 32'h0)
		else $error("precharge timer not reset by discharge");
	cu_pass_a: assert property (ce && cu_en && cu_q == CU_CHECK && cu_ok |=> !fet_hold)
		else $error("FETs still held after good copper check");
	cu_fail_a: assert property (ce && cu_en && cu_q == CU_CHECK && !cu_ok && cu_bad
		|=> ##1 perm_fail[0] && status_q[ST_COPPER_DEPOSITION_CHECK])
		else $error("copper fail not raised");
	suv_pf_a: assert property (ce && suv_met |=> perm_fail[1])
		else $error("low cell fail not latched");
	sov_pf_a: assert property (ce && sov_met && !met_q[2] |=> status_q[ST_SOV])
		else $error("high cell status not set");
	hwd_a: assert property (ce && host_comm_evt |=> !hwd_met)
		else $error("watchdog not restarted by host traffic");
	hwd_st_a: assert property (ce && hwd_met && !met_q[4] |=> status_q[ST_HWD])
		else $error("watchdog fault not reported");
	rec_a: assert property (ce && !recov_cond[0] && tick |=> !recov_done[0])
		else $error("recovery held without condition");
endmodule : bpt_top

// ### test/tb.sv
module tb import bpt_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	// Short second keeps every delay inside a brief run
	localparam int SC = 10;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic host_comm_evt = 1'b0;
	logic [15:0] min_cell_mv = 16'h0e74;
	logic [15:0] max_cell_mv = 16'h0e74;
	logic signed [15:0] current_user = 16'sh0000;
	logic precharge_mode = 1'b0;
	logic dsg_latch_fault = 1'b0;
	logic ld_pin_high = 1'b0;
	logic [3:0] recov_cond = 4'h0;
	logic [3:0] recov_done;
	logic ld_source_en;
	logic ld_recover;
	logic fet_hold;
	logic precharge_suspend_flag;
	logic precharge_limit_protection;
	logic [2:0] perm_fail;
	logic irq;
	int miscompares = 0;
	int tests_run = 0;

	bpt_top #(.SEC_CYCLES_P(SC), .NREC(4)) dut (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .host_comm_evt(host_comm_evt),
		.min_cell_mv(min_cell_mv), .max_cell_mv(max_cell_mv), .current_user(current_user),
		.precharge_mode(precharge_mode), .dsg_latch_fault(dsg_latch_fault),
		.ld_pin_high(ld_pin_high), .recov_cond(recov_cond), .recov_done(recov_done),
		.ld_source_en(ld_source_en), .ld_recover(ld_recover), .fet_hold(fet_hold),
		.precharge_suspend_flag(precharge_suspend_flag),
		.precharge_limit_protection(precharge_limit_protection), .perm_fail(perm_fail), .irq(irq));

	always #10 clk = ~clk;

	task give_verdict;
		$display("miscompares %0d tests_run %0d", miscompares, tests_run);
		if (miscompares == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict

	task hang(input string nm);
		miscompares++;
		$display("wrong value %s expected completion seen timeout", nm);
		give_verdict();
	endtask : hang

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	// Request held until pready is sampled high; one idle cycle follows
	task apb(input logic w, input int idx, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= 8'(idx * 4);
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) hang("apb ready");
		@(posedge clk);
	endtask : apb

	task wr(input int idx, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, idx, d, r, e);
	endtask : wr

	task rd(input int idx, output logic [31:0] r);
		logic e;
		apb(1'b0, idx, 32'h00000000, r, e);
	endtask : rd

	task wsrc(input logic lvl, output int n);
		n = 0;
		while (ld_source_en !== lvl && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (n >= 100) hang("load source wait");
	endtask : wsrc

	task do_reset;
		rst_n <= 1'b0;
		cyc(20);
		rst_n <= 1'b1;
		cyc(1);
	endtask : do_reset

	// FETs held until cells qualify good
	task t_copper_pass;
		logic [31:0] r;
		chk("fet hold at start", {31'h0, fet_hold}, 32'h1);
		cyc(35);
		chk("fet hold released", {31'h0, fet_hold}, 32'h0);
		rd(I_STATE, r);
		chk("copper state pass", {30'h0, r[7:6]}, 32'h1);
	endtask : t_copper_pass

	task t_regs;
		logic [31:0] r;
		logic e;
		for (int i = 0; i < NCFG; i++) begin
			rd(i, r);
			chk("config reset", r, {16'h0000, CFG_RST[i]});
		end
		rd(I_MASK, r);
		chk("mask reset", r, 32'h0);
		apb(1'b0, 19, 32'h00000000, r, e);
		chk("unmapped error", {31'h0, e}, 32'h1);
		chk("unmapped data", r, 32'h0);
		wr(I_LD_ACT, 32'hffffffff);
		rd(I_LD_ACT, r);
		chk("active time width", r, 32'h000000ff);
		wr(I_LD_ACT, 32'h0);
	endtask : t_regs

	// silence trips the watchdog, traffic restarts it
	task t_watchdog;
		logic [31:0] r;
		wr(I_HWD_TMO, 32'h3);
		wr(I_MASK, 32'h1);
		host_comm_evt <= 1'b1;
		@(posedge clk);
		host_comm_evt <= 1'b0;
		cyc(18);
		chk("watchdog early", {31'h0, irq}, 32'h0);
		cyc(20);
		chk("watchdog irq", {31'h0, irq}, 32'h1);
		wr(I_MASK, 32'h0);
		chk("masked irq", {31'h0, irq}, 32'h0);
		host_comm_evt <= 1'b1;
		@(posedge clk);
		host_comm_evt <= 1'b0;
		wr(I_STATUS, 32'h1);
		rd(I_STATUS, r);
		chk("status cleared", {31'h0, r[ST_HWD]}, 32'h0);
		wr(I_MASK, 32'h1);
		chk("irq after clear", {31'h0, irq}, 32'h0);
		wr(I_HWD_TMO, 32'hffff);
		wr(I_MASK, 32'h0);
	endtask : t_watchdog

	// recovery qualifies over whole seconds, restarts on a gap
	task t_recovery;
		wr(I_RECOV_TIME, 32'h2);
		recov_cond <= 4'h2;
		cyc(9);
		chk("recovery early", {28'h0, recov_done}, 32'h0);
		cyc(30);
		chk("recovery done", {28'h0, recov_done}, 32'h2);
		recov_cond <= 4'h0;
		cyc(12);
		recov_cond <= 4'h2;
		cyc(9);
		chk("recovery restart", {28'h0, recov_done}, 32'h0);
		recov_cond <= 4'h0;
	endtask : t_recovery

	// suspend at threshold, trip at delay, discharge reset
	task t_precharge;
		wr(I_PRECHARGE_LIMIT_DELAY, 32'h3);
		precharge_mode <= 1'b1;
		current_user <= 16'sd250;
		cyc(2);
		chk("suspend at threshold", {31'h0, precharge_suspend_flag}, 32'h1);
		cyc(50);
		chk("held timer", {31'h0, precharge_limit_protection}, 32'h0);
		current_user <= 16'sd251;
		cyc(2);
		chk("suspend off", {31'h0, precharge_suspend_flag}, 32'h0);
		cyc(17);
		chk("precharge early", {31'h0, precharge_limit_protection}, 32'h0);
		cyc(20);
		chk("precharge trip", {31'h0, precharge_limit_protection}, 32'h1);
		precharge_mode <= 1'b0;
		current_user <= -16'sd1000;
		cyc(65);
		chk("discharge short", {31'h0, precharge_limit_protection}, 32'h1);
		cyc(40);
		chk("discharge reset", {31'h0, precharge_limit_protection}, 32'h0);
		current_user <= 16'sd0;
	endtask : t_precharge

	// load removal duty cycle and timeout
	task t_load;
		logic [31:0] r;
		int n;
		dsg_latch_fault <= 1'b1;
		cyc(30);
		chk("no source at zero", {31'h0, ld_source_en}, 32'h0);
		wr(I_LD_RETRY, 32'h3);
		// active time spans a voltage sample
		wr(I_LD_ACT, 32'h2);
		wsrc(1'b1, n);
		wsrc(1'b0, n);
		chk("first on span", 32'(n >= 10 && n <= 21), 32'h1);
		wsrc(1'b1, n);
		chk("off span", 32'(n), 32'(3 * SC));
		wsrc(1'b0, n);
		chk("on span", 32'(n), 32'(2 * SC));
		wsrc(1'b1, n);
		ld_pin_high <= 1'b1;
		@(posedge clk);
		chk("removal pulse", {31'h0, ld_recover}, 32'h1);
		dsg_latch_fault <= 1'b0;
		ld_pin_high <= 1'b0;
		cyc(2);
		chk("source off after", {31'h0, ld_source_en}, 32'h0);
		rd(I_STATUS, r);
		chk("removal status", {31'h0, r[ST_LD_RECOV]}, 32'h1);
		wr(I_LD_RETRY, 32'h0);
		dsg_latch_fault <= 1'b1;
		wsrc(1'b1, n);
		cyc(50);
		chk("source stays on", {31'h0, ld_source_en}, 32'h1);
		wr(I_LD_TMO_HRS, 32'h0);
		cyc(15);
		rd(I_STATE, r);
		chk("load expired", {30'h0, r[9:8]}, 32'h3);
		chk("expired source", {31'h0, ld_source_en}, 32'h0);
		rd(I_STATUS, r);
		chk("timeout status", {31'h0, r[ST_LD_TMO]}, 32'h1);
		wr(I_LD_TMO_HRS, 32'h1);
		wr(I_CTRL, 32'h3);
		cyc(3);
		chk("retry command", {31'h0, ld_source_en}, 32'h1);
		dsg_latch_fault <= 1'b0;
		cyc(2);
	endtask : t_load

	// boundary voltages qualify after the default delay
	task t_cells;
		min_cell_mv <= 16'd2200;
		max_cell_mv <= 16'd4499;
		cyc(39);
		chk("low cell early", {29'h0, perm_fail}, 32'h0);
		cyc(30);
		chk("low cell fail", {29'h0, perm_fail}, 32'h2);
		max_cell_mv <= 16'd4500;
		cyc(39);
		chk("high cell early", {29'h0, perm_fail}, 32'h2);
		cyc(30);
		chk("high cell fail", {29'h0, perm_fail}, 32'h6);
	endtask : t_cells

	// low clock enable freezes the qualifiers
	task t_freeze;
		ce <= 1'b0;
		recov_cond <= 4'h1;
		cyc(40);
		chk("frozen recovery", {28'h0, recov_done}, 32'h0);
		ce <= 1'b1;
		cyc(30);
		chk("recovery after freeze", {28'h0, recov_done}, 32'h1);
		recov_cond <= 4'h0;
	endtask : t_freeze

	// a low cell after reset fails the copper check
	task t_copper_fail;
		min_cell_mv <= 16'd1000;
		max_cell_mv <= 16'd3700;
		do_reset();
		cyc(35);
		chk("copper fail", {29'h0, perm_fail}, 32'h1);
		chk("fets still held", {31'h0, fet_hold}, 32'h1);
	endtask : t_copper_fail

	initial begin
		do_reset();
		t_copper_pass();
		t_regs();
		t_watchdog();
		t_recovery();
		t_precharge();
		t_load();
		t_cells();
		t_freeze();
		t_copper_fail();
		give_verdict();
	end
endmodule : tb
